// ==== core/clock_source_select.sv ====
// Purpose: time-base source selection and power-on register load
// Assumes: ext_clk_pin is sampled as a synchronous level on clk_sys
// Notes:   the time base is a one-cycle tick per selected clock period
module clock_source_select
  import clk_por_pkg::*;
#(
  parameter int                               N_REGS    = NUM_REGS,
  parameter logic [N_REGS-1:0][REG_W-1:0]     REG_RST   = REG_DEFAULTS,
  parameter logic [N_REGS-1:0]                LOAD_MASK = OTP_LOAD_MASK,
  parameter int                               TIMEOUT   = EXT_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // external clock pin
  input  wire logic                          ext_clk_pin,
  // one-time memory port
  output clk_por_pkg::otp_req_s              otp_req,
  input  wire clk_por_pkg::otp_rsp_s         otp_rsp,
  // time base and configuration to the driver
  output clk_por_pkg::timebase_s             tb,
  output logic [N_REGS-1:0][REG_W-1:0]       cfg,
  output logic                               init_done
);
  import clk_por_pkg::*;

  typedef struct packed {
    src_e                         src;
    logic                         ext_prev;
    logic [DIV_W-1:0]             div;
    logic [SUP_W-1:0]             sup;
    logic [N_REGS-1:0][REG_W-1:0] regs;
    timebase_s                    tb;
  } st_s;

  st_s               q, d;
  reg_wr_s           wr;
  logic              ld_done;
  logic [TRIM_W-1:0] trim;
  logic [DIV_W-1:0]  div_lim;
  logic              osc_tick;
  logic              ext_rise;
  logic              sel_tick;

  otp_default_loader #(
    .N_REGS    (N_REGS),
    .LOAD_MASK (LOAD_MASK)
  ) u_loader (
    .clk_sys (clk_sys),
    .rst     (rst),
    .otp_req (otp_req),
    .otp_rsp (otp_rsp),
    .wr      (wr),
    .done    (ld_done)
  );

  // oscillator model: signed trim around the nominal divide
  assign trim     = q.regs[0][TRIM_LSB +: TRIM_W];
  assign div_lim  = DIV_W'(OSC_DIV_NOM) + {trim[TRIM_W-1], trim};
  // >= keeps the divider sane if a new trim lands below the count
  assign osc_tick = (q.div >= div_lim - 1'b1);
  assign ext_rise = ext_clk_pin & ~q.ext_prev;

  always_comb begin
    d             = q;
    sel_tick      = 1'b0;
    d.tb.tick     = 1'b0;
    d.tb.ext_lost = 1'b0;
    d.ext_prev    = ext_clk_pin;
    d.div         = osc_tick ? '0 : q.div + 1'b1;
    unique case (q.src)
      SRC_INT: begin
        sel_tick = osc_tick;
        if (ext_rise) begin
          // detecting edge is not a tick: the first external tick
          // comes one full external period later
          d.src    = SRC_EXT;
          d.sup    = '0;
          sel_tick = 1'b0;
        end
      end
      SRC_EXT: begin
        sel_tick = ext_rise;
        if (ext_rise) begin
          d.sup = '0;
        end else if (osc_tick) begin
          if (q.sup == SUP_W'(TIMEOUT - 1)) begin
            d.src         = SRC_FAIL;
            d.tb.ext_lost = 1'b1;
          end else begin
            d.sup = q.sup + 1'b1;
          end
        end
      end
      SRC_FAIL: begin
        // rejoin on an oscillator edge so the first internal tick
        // follows a whole oscillator period
        if (osc_tick) begin
          d.src = SRC_INT;
        end
      end
      default: d.src = SRC_INT;
    endcase
    // downstream timing waits for the power-up load to finish
    d.tb.tick       = sel_tick & ld_done;
    d.tb.ext_active = (d.src == SRC_EXT);
    if (d.tb.tick) begin
      d.tb.count = q.tb.count + 1'b1;
    end
    if (wr.en) begin
      d.regs[wr.idx] = wr.data;
    end
    if (rst) begin
      d          = '0;
      d.src      = SRC_INT;
      d.regs     = REG_RST;
      d.ext_prev = 1'b1; // a pin already high at reset is no edge
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign tb        = q.tb;
  assign cfg       = q.regs;
  assign init_done = ld_done;

  // checks
  localparam int FAIL_BOUND = 64;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_int_tick_source: assert property (
    q.src == SRC_INT && osc_tick && !ext_rise && ld_done |=> tb.tick)
    else $error("internal tick missing");

  chk_ext_first_edge: assert property (
    q.src == SRC_INT && ext_rise |=> q.src == SRC_EXT && !tb.tick)
    else $error("no switch on first external edge");

  chk_timeout_exact: assert property (
    $rose(q.src == SRC_FAIL) |-> $past(q.sup) == SUP_W'(TIMEOUT - 1)
      && $past(q.src) == SRC_EXT && tb.ext_lost)
    else $error("external failure declared at wrong count");

  chk_timeout_taken: assert property (
    q.src == SRC_EXT && osc_tick && !ext_rise
      && q.sup == SUP_W'(TIMEOUT - 1) |=> q.src == SRC_FAIL)
    else $error("external failure missed");

  chk_fallback_int: assert property (
    q.src == SRC_FAIL |-> ##[1:FAIL_BOUND] q.src == SRC_INT)
    else $error("no fallback to internal clock");

  chk_tb_count_step: assert property (
    tb.tick |-> tb.count == $past(tb.count) + 1'b1)
    else $error("time base count not stepped by tick");

  // this check must see rst high, so it opts out of the default disable
  chk_por_defaults: assert property (
    @(posedge clk_sys) disable iff (1'b0)
      rst |=> q.regs == REG_RST && q.src == SRC_INT)
    else $error("reset defaults not loaded");

  chk_otp_copy: assert property (
    wr.en |=> q.regs[$past(wr.idx)] == $past(wr.data))
    else $error("one-time value not copied");

  chk_switch_no_runt: assert property (
    q.src != $past(q.src) |-> !tb.tick ##1 !tb.tick)
    else $error("tick emitted at source switch");

  // a tick wider than one cycle would count twice downstream
  chk_tick_one_cycle: assert property (
    tb.tick |=> !tb.tick)
    else $error("tick longer than one cycle");

  chk_no_tick_loading: assert property (
    !ld_done |=> !tb.tick)
    else $error("tick before power-up load finished");

  chk_count_hold: assert property (
    !tb.tick && !$past(rst) |-> $stable(tb.count))
    else $error("time base count moved without tick");

  chk_lost_pulse: assert property (
    tb.ext_lost |=> !tb.ext_lost)
    else $error("failure pulse longer than one cycle");

  chk_sup_cleared: assert property (
    q.src == SRC_EXT && ext_rise |=> q.sup == '0)
    else $error("supervision count not cleared by edge");

  chk_fail_no_tick: assert property (
    q.src == SRC_FAIL |=> !tb.tick)
    else $error("tick while rejoining internal clock");

  chk_marked_only: assert property (
    wr.en |-> LOAD_MASK[wr.idx])
    else $error("unmarked word loaded from one-time memory");

  cov_go_ext: cover property (q.src == SRC_INT ##1 q.src == SRC_EXT);
  cov_ext_tick: cover property (q.src == SRC_EXT && tb.tick);
  cov_ext_fail: cover property (tb.ext_lost);
  cov_back_int: cover property (q.src == SRC_FAIL ##1 q.src == SRC_INT);
  cov_load_done: cover property ($rose(ld_done));

endmodule

// ==== core/otp_default_loader.sv ====
// Purpose: after reset, read the marked register words from one-time memory
// Assumes: memory answers a held request with a one-cycle ack and data
// Notes:   words not marked keep their fixed power-on value
module otp_default_loader
  import clk_por_pkg::*;
#(
  parameter int                  N_REGS    = NUM_REGS,
  parameter logic [N_REGS-1:0]   LOAD_MASK = OTP_LOAD_MASK
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // one-time memory port
  output clk_por_pkg::otp_req_s otp_req,
  input  wire clk_por_pkg::otp_rsp_s otp_rsp,
  // register file side
  output clk_por_pkg::reg_wr_s  wr,
  output logic                  done
);
  import clk_por_pkg::*;

  typedef struct packed {
    ld_e               st;
    logic [OTP_AW-1:0] idx;
  } ld_state_s;

  ld_state_s q, d;
  logic      last;

  assign last = (q.idx == OTP_AW'(N_REGS - 1));

  always_comb begin
    d       = q;
    otp_req = '0;
    wr      = '0;
    unique case (q.st)
      LD_SCAN: begin
        if (LOAD_MASK[q.idx]) begin
          d.st = LD_WAIT;
        end else if (last) begin
          d.st = LD_DONE;
        end else begin
          d.idx = q.idx + 1'b1;
        end
      end
      LD_WAIT: begin
        otp_req.req  = 1'b1;
        otp_req.addr = q.idx;
        if (otp_rsp.ack) begin
          wr.en   = 1'b1;
          wr.idx  = q.idx;
          wr.data = otp_rsp.data;
          d.st    = last ? LD_DONE : LD_SCAN;
          d.idx   = last ? q.idx : q.idx + 1'b1;
        end
      end
      LD_DONE: begin
      end
      default: d.st = LD_DONE;
    endcase
    if (rst) begin
      d = '{st: LD_SCAN, idx: '0};
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign done = (q.st == LD_DONE);

endmodule

// ==== dv/otp_mem_model.sv ====
// Purpose: one-time memory seen by the power-up loader
// Assumes: the loader holds its request until the ack
// Notes:   off the ack cycle the data bus toggles so a late sample shows
module otp_mem_model
  import clk_por_pkg::*;
#(
  parameter int                             DLY   = 2,
  parameter logic [NUM_REGS-1:0][REG_W-1:0] WORDS = 64'h0000_1234_0000_0002
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // memory port
  input  wire clk_por_pkg::otp_req_s otp_req,
  output clk_por_pkg::otp_rsp_s      otp_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  always_ff @(posedge clk_sys) begin
    otp_rsp.data <= ~otp_rsp.data;
    if (rst) begin
      otp_rsp <= '{ack: 1'b0, data: 16'hA5A5};
      wait_q  <= 0;
    end else if (otp_rsp.ack) begin
      otp_rsp.ack <= 1'b0;
      wait_q      <= 0;
    end else if (otp_req.req && wait_q == DLY) begin
      otp_rsp.ack  <= 1'b1;
      otp_rsp.data <= WORDS[otp_req.addr];
    end else if (otp_req.req) begin
      wait_q <= wait_q + 1;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for clock source select and power-on load
// Assumes: memory word0 trim 2, so the internal period is 22 cycles
// Notes:   pin driven on falling edges; ext periods stay within 4..16MHz
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_por_pkg::*;
  logic                           clk_sys, rst, ext_clk_pin, ext_on;
  otp_req_s                       otp_req;
  otp_rsp_s                       otp_rsp;
  timebase_s                      tbase;
  logic [NUM_REGS-1:0][REG_W-1:0] cfg;
  logic                           init_done;
  int failures, n_compared, cyc, half, ph, n, c0;
  logic [REG_W-1:0] exp_cfg [NUM_REGS] = '{16'h0002, REG1_RST, 16'h1234,
                                           REG3_RST};
  // ext half period, expected spacing of ticks in cycles
  int rows [4][2] = '{'{8, 16}, '{10, 20}, '{15, 30}, '{31, 62}};

  clock_source_select u_clock_source_select (.clk_sys(clk_sys), .rst(rst),
    .ext_clk_pin(ext_clk_pin), .otp_req(otp_req), .otp_rsp(otp_rsp),
    .tb(tbase), .cfg(cfg), .init_done(init_done));
  otp_mem_model #(.DLY(3)) u_otp_mem_model (.clk_sys(clk_sys), .rst(rst),
    .otp_req(otp_req), .otp_rsp(otp_rsp));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // free-running external source; holds its last level when switched off
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    if (ext_on) begin
      ph = ph + 1;
      if (ph >= half) begin
        ph = 0;
        ext_clk_pin <= ~ext_clk_pin;
      end
    end
    if (cyc > 20000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic chk_word(logic [REG_W-1:0] got, logic [REG_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_int(int got, int exp);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (tbase.tick !== 1'b1 && k < 2000);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < NUM_REGS; i++) chk_word(cfg[i], REG_DEFAULTS[i]);
    chk_word({15'h0, init_done | tbase.tick}, 16'h0000);
    rst = 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk_word({15'h0, init_done}, 16'h0001);
    chk_word({15'h0, tbase.count != '0}, 16'h0000);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    // external pin low and its source off while reset is held
    ext_clk_pin = 1'b0;
    ext_on = 1'b0;
    cyc = 0;
    ph = 0;
    half = 10;
    failures = 0;
    n_compared = 0;
    do_reset();
    for (int i = 0; i < NUM_REGS; i++) chk_word(cfg[i], exp_cfg[i]);
    wait_tick(n);
    c0 = tbase.count;
    wait_tick(n);
    chk_int(n, 22);
    chk_int(tbase.count - c0, 1);
    chk_word({15'h0, tbase.ext_active}, 16'h0000);
    ext_on = 1'b1;
    repeat (half + 2) @(negedge clk_sys);
    chk_word({15'h0, tbase.ext_active}, 16'h0001);
    // each row: ext half period, ticks then spaced two half periods
    foreach (rows[r]) begin
      half = rows[r][0];
      repeat (2) wait_tick(n);
      wait_tick(n);
      chk_int(n, rows[r][1]);
    end
    ext_on = 1'b0;
    ext_clk_pin = 1'b0;
    n = 0;
    while (tbase.ext_lost !== 1'b1 && n < 900) begin
      @(negedge clk_sys);
      n++;
    end
    chk_int(n >= 31 * 22 - 2 && n <= 32 * 22 + 1, 1);
    @(negedge clk_sys);
    chk_word({15'h0, tbase.ext_active}, 16'h0000);
    repeat (2) wait_tick(n);
    wait_tick(n);
    chk_int(n, 22);
    // second reset in mid-run reloads defaults then memory words
    do_reset();
    chk_word(cfg[0], 16'h0002);
    chk_word(cfg[2], 16'h1234);
    tally_and_finish();
  end
endmodule

// ==== shared/clk_por_pkg.sv ====
// Purpose: shared constants and carriers for clock select and power-on load
// Assumes: clk_sys at 250 MHz; all pins synchronous to clk_sys
// Notes:   register words narrower than REG_W are not used
package clk_por_pkg;

  // timing
  localparam int CLK_SYS_HZ        = 250_000_000;
  localparam int OSC_FREQ_HZ       = 12_000_000;
  localparam int OSC_DIV_NOM       = CLK_SYS_HZ / OSC_FREQ_HZ;
  localparam int EXT_TIMEOUT_TICKS = 32;

  // widths
  localparam int TRIM_W   = 5;
  localparam int TRIM_LSB = 0;
  localparam int DIV_W    = TRIM_W + 1;
  localparam int SUP_W    = 6;
  localparam int TB_CNT_W = 24;
  localparam int NUM_REGS = 4;
  localparam int REG_W    = 16;
  localparam int OTP_AW   = 2;

  // fixed power-on values; word 0 holds the oscillator trim
  localparam logic [REG_W-1:0] REG0_RST = 16'h0000;
  localparam logic [REG_W-1:0] REG1_RST = 16'h0010;
  localparam logic [REG_W-1:0] REG2_RST = 16'h0A14;
  localparam logic [REG_W-1:0] REG3_RST = 16'h0000;
  localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_DEFAULTS =
    {REG3_RST, REG2_RST, REG1_RST, REG0_RST};
  // words replaced from one-time memory during power-up
  localparam logic [NUM_REGS-1:0] OTP_LOAD_MASK = 4'h5;

  typedef enum logic [1:0] {
    SRC_INT  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_FAIL = 2'b11
  } src_e;

  typedef enum logic [1:0] {
    LD_SCAN = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b11
  } ld_e;

  typedef struct packed {
    logic                tick;
    logic                ext_active;
    logic                ext_lost;
    logic [TB_CNT_W-1:0] count;
  } timebase_s;

  typedef struct packed {
    logic              req;
    logic [OTP_AW-1:0] addr;
  } otp_req_s;

  typedef struct packed {
    logic             ack;
    logic [REG_W-1:0] data;
  } otp_rsp_s;

  typedef struct packed {
    logic              en;
    logic [OTP_AW-1:0] idx;
    logic [REG_W-1:0]  data;
  } reg_wr_s;

endpackage
